// ---- common/adc_seq_pkg.sv ----
package adc_seq_pkg;
// Function
// - 10-bit result right aligned over two bytes, left aligned when selected.
// - Channel code 100010 routes the temperature sensor to the converter.
// - Differential codes pick gain 1x or 20x by bit 0; single ended bypasses gain.
// - Adjacent inputs pair as differential; inputs 0, 1, 5, 6 and 7 also pair with input three.
// - Reference and channel reach the analog path only while the converter is enabled.
// - Low read blocks result updates until high read; blocked results are dropped.
// - Completion flag still sets when a blocked result is dropped.
// - Start write begins conversion; start bit reads one while busy, clears on completion except when free running.
// - Channel change during conversion takes effect only from its last ADC cycle.
// - Auto trigger rising edge resets prescaler and starts; edges while busy ignored.
// - Trigger level still high at completion does not start another conversion.
// - Own completion flag as source converts continuously; first needs a start write.
// - Prescaler select sets ratio; prescaler runs while enabled, held reset otherwise.
// - Software start begins at the next rising ADC clock edge.
// - Normal conversion lasts 13 ADC cycles, first after enable lasts 25.
// - Sampling at 1.5 ADC cycles normally, 13.5 for the first conversion.
// - Completion writes results, sets flag, and clears start bit in single mode.
// - Auto triggered: sample two ADC cycles after trigger, conversion spans 13.5.
// - Auto trigger adds three system clock cycles of synchronisation before launch.
// - Free running restarts right after completion, start bit high, sample 2.5, total 14.
// - Two-bit reference field picks supply, external reference pin, or internal 1.1V.
// - Selections buffered, locked at start, updating again in the last ADC cycle.

  localparam int RES_W = 10;
  localparam int TRIG_N = 8;

  // channel codes
  localparam logic [5:0] TEMP_CODE = 6'h22;
  localparam logic [5:0] DIFF_LO   = 6'h08;
  localparam logic [5:0] DIFF_HI   = 6'h1f;
  localparam logic [3:0] PAIR_BASE = 4'h4;
  localparam logic [2:0] COMMON_IN = 3'h3;

  // reference codes
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_EXT    = 2'h1;
  localparam logic [1:0] REF_INT    = 2'h2;

  // trigger source that selects free running
  localparam logic [2:0] SRC_SELF = 3'h0;

  // conversion shapes in ADC half cycles
  localparam logic [7:0] FIRST_TOTAL = 8'h32;
  localparam logic [7:0] FIRST_SAMP  = 8'h1b;
  localparam logic [7:0] NORM_TOTAL  = 8'h1a;
  localparam logic [7:0] NORM_SAMP   = 8'h03;
  localparam logic [7:0] AUTO_TOTAL  = 8'h1b;
  localparam logic [7:0] AUTO_SAMP   = 8'h04;
  localparam logic [7:0] FREE_TOTAL  = 8'h1c;
  localparam logic [7:0] FREE_SAMP   = 8'h05;
  localparam logic [7:0] LAST_CYCLE  = 8'h02;

  // trigger synchronisation, system clock cycles
  localparam logic [1:0] SYNC_LAST = 2'h2;

endpackage : adc_seq_pkg

// ---- rtl/adc_prescaler.sv ----
`timescale 1ns/1ps
module adc_prescaler
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] select,
  // ADC clock edges
  output logic            adc_rise,
  output logic            adc_fall
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] ratio_m1;
  logic [7:0] half_m1;

  assign ratio_m1 = 8'((9'h002 << select) - 9'h001);
  assign half_m1  = 8'((9'h001 << select) - 9'h001);

  assign adc_rise = run && (cnt == ratio_m1);
  assign adc_fall = run && (cnt == half_m1);

  always_comb begin
    next_cnt = cnt + 8'h01;
    if (!run || restart || adc_rise) begin
      next_cnt = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule : adc_prescaler

// ---- rtl/channel_decode.sv ----
`timescale 1ns/1ps
module channel_decode
  import adc_seq_pkg::*;
(
  // selection code
  input  wire logic [5:0] code,
  // decoded path
  output logic            is_diff,
  output logic            is_temp,
  output logic            gain_hi,
  output logic [2:0]      pos,
  output logic [2:0]      neg
);

  logic [3:0] pair;

  assign pair = code[4:1] - PAIR_BASE;

  always_comb begin
    is_temp = (code == TEMP_CODE);
    is_diff = (code >= DIFF_LO) && (code <= DIFF_HI);
    gain_hi = is_diff && code[0];
    pos     = code[2:0];
    neg     = 3'h0;
    // adjacent pairs, then pairs against input three
    if (is_diff) begin
      neg = COMMON_IN;
      unique case (pair)
        4'h7:    pos = 3'h0;
        4'h8:    pos = 3'h1;
        4'h9:    pos = 3'h5;
        4'ha:    pos = 3'h6;
        4'hb:    pos = 3'h7;
        default: begin
          pos = pair[2:0];
          neg = pair[2:0] + 3'h1;
        end
      endcase
    end
  end

endmodule : channel_decode

// ---- rtl/sar_adc_sequencer.sv ----
`timescale 1ns/1ps
module sar_adc_sequencer
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // control bits
  input  wire logic              converter_enable,
  input  wire logic              start_write,
  input  wire logic              auto_trigger_enable,
  input  wire logic [2:0]        trigger_source_select,
  input  wire logic [2:0]        prescaler_select,
  input  wire logic              left_align_select,
  // selection bits
  input  wire logic [1:0]        reference_select,
  input  wire logic [5:0]        channel_select,
  // result access
  input  wire logic              result_low_read,
  input  wire logic              result_high_read,
  input  wire logic              flag_clear,
  // trigger sources, index 0 stands for the own flag
  input  wire logic [TRIG_N-1:0] trigger_sources,
  // analog core
  input  wire logic [RES_W-1:0]  core_result,
  // status
  output logic                   start_conversion,
  output logic                   conversion_done_flag,
  output logic [7:0]             result_low,
  output logic [7:0]             result_high,
  // analog path
  output logic                   analog_enable,
  output logic [1:0]             ref_applied,
  output logic [2:0]             pos_input,
  output logic [2:0]             neg_input,
  output logic                   diff_mode,
  output logic                   gain_20x,
  output logic                   temp_sensor_sel,
  output logic                   sample_hold,
  output logic                   conv_finish
);

  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_SYNC, ST_CONV} state_e;

  state_e     state;
  state_e     next_state;
  logic [7:0] half_cnt;
  logic [7:0] next_half;
  logic [7:0] total;
  logic [7:0] next_total;
  logic [7:0] samp;
  logic [7:0] next_samp;
  logic [1:0] sync_cnt;
  logic [1:0] next_sync;
  logic       first_pend;
  logic       next_first;

  logic       adc_rise;
  logic       adc_fall;
  logic       adc_edge;
  logic       trig_prev;
  logic       trig_level;
  logic       trig_edge;
  logic       free_run;
  logic       ext_trig;
  logic       done;
  logic       samp_hit;
  logic       sync_done;
  logic       buf_lock;
  logic       blocked;

  logic       lock;
  logic       next_lock;
  logic       next_flag;
  logic [7:0] next_res_lo;
  logic [7:0] next_res_hi;
  logic [1:0] buf_ref;
  logic [5:0] buf_chan;
  logic [1:0] next_buf_ref;
  logic [5:0] next_buf_chan;

  logic       dec_diff;
  logic       dec_temp;
  logic       dec_gain;
  logic [2:0] dec_pos;
  logic [2:0] dec_neg;

  ////////////////////////////////////////////////////////////////////
  // clock generation and channel decode

  adc_prescaler u_prescaler (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .run      (converter_enable),
    .restart  (sync_done),
    .select   (prescaler_select),
    .adc_rise (adc_rise),
    .adc_fall (adc_fall)
  );

  channel_decode u_decode (
    .code    (buf_chan),
    .is_diff (dec_diff),
    .is_temp (dec_temp),
    .gain_hi (dec_gain),
    .pos     (dec_pos),
    .neg     (dec_neg)
  );

  ////////////////////////////////////////////////////////////////////
  // trigger and timing terms

  assign adc_edge   = adc_rise || adc_fall;
  assign trig_level = trigger_sources[trigger_source_select];
  // edge only, a held level never retriggers
  assign trig_edge  = trig_level && !trig_prev;
  // own flag source means free running
  assign free_run   = auto_trigger_enable && (trigger_source_select == SRC_SELF);
  assign ext_trig   = auto_trigger_enable && !free_run && trig_edge;
  assign done       = (state == ST_CONV) && adc_edge && (half_cnt + 8'h01 == total);
  assign samp_hit   = (state == ST_CONV) && adc_edge && (half_cnt + 8'h01 == samp);
  assign sync_done  = (state == ST_SYNC) && (sync_cnt == SYNC_LAST);
  // locked until the last ADC cycle
  assign buf_lock   = (state == ST_CONV) && (half_cnt + LAST_CYCLE < total);
  assign blocked    = lock || result_low_read;

  ////////////////////////////////////////////////////////////////////
  // conversion sequencer

  always_comb begin
    next_state = state;
    next_half  = half_cnt;
    next_total = total;
    next_samp  = samp;
    next_sync  = sync_cnt;
    next_first = first_pend;
    if ((state == ST_CONV) && adc_edge) begin
      next_half = half_cnt + 8'h01;
    end
    unique case (state)
      ST_IDLE: begin
        if (start_write) begin
          next_state = ST_ARM;
        end else if (ext_trig) begin
          next_state = ST_SYNC;
          next_sync  = 2'h0;
        end
      end
      ST_ARM: begin
        if (adc_rise) begin
          next_state = ST_CONV;
          next_half  = 8'h00;
          next_first = 1'b0;
          next_total = first_pend ? FIRST_TOTAL : NORM_TOTAL;
          next_samp  = first_pend ? FIRST_SAMP : NORM_SAMP;
        end
      end
      ST_SYNC: begin
        if (sync_done) begin
          next_state = ST_CONV;
          next_half  = 8'h00;
          next_first = 1'b0;
          next_total = first_pend ? FIRST_TOTAL : AUTO_TOTAL;
          next_samp  = first_pend ? FIRST_SAMP : AUTO_SAMP;
        end else begin
          next_sync = sync_cnt + 2'h1;
        end
      end
      ST_CONV: begin
        if (done) begin
          if (free_run) begin
            next_half  = 8'h00;
            next_total = FREE_TOTAL;
            next_samp  = FREE_SAMP;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
    endcase
    // disabling aborts and rearms the long first conversion
    if (!converter_enable) begin
      next_state = ST_IDLE;
      next_first = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      half_cnt   <= 8'h00;
      total      <= NORM_TOTAL;
      samp       <= NORM_SAMP;
      sync_cnt   <= 2'h0;
      first_pend <= 1'b1;
      trig_prev  <= 1'b0;
    end else begin
      state      <= next_state;
      half_cnt   <= next_half;
      total      <= next_total;
      samp       <= next_samp;
      sync_cnt   <= next_sync;
      first_pend <= next_first;
      trig_prev  <= trig_level;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flag, result lock and result registers

  always_comb begin
    // set wins over clear, also when result dropped
    next_flag   = (conversion_done_flag && !flag_clear) || done;
    // low read locks, high read unlocks
    next_lock   = (lock || result_low_read) && !result_high_read;
    next_res_lo = result_low;
    next_res_hi = result_high;
    if (done && !blocked) begin
      if (left_align_select) begin
        next_res_hi = core_result[9:2];
        next_res_lo = {core_result[1:0], 6'h00};
      end else begin
        next_res_hi = {6'h00, core_result[9:8]};
        next_res_lo = core_result[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      conversion_done_flag <= 1'b0;
      lock                 <= 1'b0;
      result_low           <= 8'h00;
      result_high          <= 8'h00;
    end else begin
      conversion_done_flag <= next_flag;
      lock                 <= next_lock;
      result_low           <= next_res_lo;
      result_high          <= next_res_hi;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // selection buffer and analog path

  always_comb begin
    next_buf_ref  = buf_ref;
    next_buf_chan = buf_chan;
    // old channel kept for the running conversion
    if (!buf_lock) begin
      next_buf_ref  = reference_select;
      next_buf_chan = channel_select;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      buf_ref          <= REF_SUPPLY;
      buf_chan         <= 6'h00;
      ref_applied      <= REF_SUPPLY;
      pos_input        <= 3'h0;
      neg_input        <= 3'h0;
      diff_mode        <= 1'b0;
      gain_20x         <= 1'b0;
      temp_sensor_sel  <= 1'b0;
      analog_enable    <= 1'b0;
      start_conversion <= 1'b0;
      sample_hold      <= 1'b0;
      conv_finish      <= 1'b0;
    end else begin
      buf_ref          <= next_buf_ref;
      buf_chan         <= next_buf_chan;
      analog_enable    <= converter_enable;
      start_conversion <= (next_state != ST_IDLE);
      sample_hold      <= samp_hit;
      conv_finish      <= done;
      if (converter_enable) begin
        // reference code passed to the analog side
        ref_applied     <= buf_ref;
        pos_input       <= dec_pos;
        neg_input       <= dec_neg;
        diff_mode       <= dec_diff;
        gain_20x        <= dec_gain;
        temp_sensor_sel <= dec_temp;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_sync_wait;
    (state == ST_SYNC) [*3];
  endsequence

  sequence s_launch;
    (state == ST_CONV) && (half_cnt == 8'h00);
  endsequence

  sequence s_temp_held;
    converter_enable && !buf_lock && (channel_select == TEMP_CODE);
  endsequence

  a_sync_delay: assert property (
    disable iff (!rst_n || !converter_enable)
    (state == ST_IDLE) && !start_write && ext_trig |=> s_sync_wait ##1 s_launch)
    else $error("auto trigger launch not three cycles after edge");

  a_arm_start: assert property (
    (state == ST_ARM) && adc_rise && converter_enable |=> s_launch)
    else $error("software start missed the rising ADC edge");

  a_flag_done: assert property (
    done |=> conversion_done_flag)
    else $error("completion flag not set");

  a_start_clear: assert property (
    done && !free_run |=> !start_conversion)
    else $error("start bit not cleared at single completion");

  a_free_keep: assert property (
    done && free_run && converter_enable |=> start_conversion
    && (total == FREE_TOTAL) && (samp == FREE_SAMP))
    else $error("free running did not restart with its shape");

  a_lock_hold: assert property (
    done && lock |=> $stable(result_low) && $stable(result_high))
    else $error("locked result registers changed");

  a_disabled_hold: assert property (
    !converter_enable |=> $stable(ref_applied) && $stable(pos_input))
    else $error("analog selection moved while disabled");

  a_first_shape: assert property (
    $rose(state == ST_CONV) && $past(first_pend)
    |-> (total == FIRST_TOTAL) && (samp == FIRST_SAMP))
    else $error("first conversion shape wrong");

  a_trig_ignore: assert property (
    (state == ST_CONV) && trig_edge |=> state != ST_SYNC)
    else $error("trigger edge accepted while busy");

  a_no_retrig: assert property (
    done && !free_run && trig_level && trig_prev
    && converter_enable |=> state == ST_IDLE)
    else $error("held trigger level restarted a conversion");

  a_busy_start: assert property (
    (state != ST_IDLE) |-> start_conversion)
    else $error("start bit low during conversion");

  a_temp_route: assert property (
    s_temp_held ##1 s_temp_held |=> temp_sensor_sel)
    else $error("temperature sensor not routed");

endmodule : sar_adc_sequencer

// ---- sim/analog_core_model.sv ----
`timescale 1ns/1ps
module analog_core_model
  import adc_seq_pkg::*;
(
  // clock
  input  wire logic             sys_clk,
  // analog path from the sequencer
  input  wire logic [1:0]       ref_applied,
  input  wire logic [2:0]       pos_input,
  input  wire logic [2:0]       neg_input,
  input  wire logic             diff_mode,
  input  wire logic             gain_20x,
  input  wire logic             temp_sensor_sel,
  input  wire logic             sample_hold,
  input  wire logic             conv_finish,
  // conversion value
  output logic [RES_W-1:0]      core_result
);
  // value encodes the sampled path, so a wrong selection shows in the result
  initial core_result = 10'h155;
  always @(posedge sys_clk) begin
    if (sample_hold) begin
      core_result <= {ref_applied, temp_sensor_sel, diff_mode, gain_20x,
                      temp_sensor_sel ? 3'h0 : pos_input, diff_mode ? neg_input[1:0] : 2'h0};
    end else if (conv_finish) begin
      // released after completion: no stale value for a late sampler
      core_result <= ~core_result;
    end
  end
endmodule : analog_core_model

// ---- sim/sar_adc_sequencer_bench.sv ----
`timescale 1ns/1ps
module sar_adc_sequencer_bench
  import adc_seq_pkg::*;
;
  logic              sys_clk, rst_n, converter_enable, start_write, auto_trigger_enable;
  logic              left_align_select, result_low_read, result_high_read, flag_clear;
  logic [2:0]        trigger_source_select, prescaler_select, pos_input, neg_input;
  logic [1:0]        reference_select, ref_applied;
  logic [5:0]        channel_select;
  logic [TRIG_N-1:0] trigger_sources;
  logic [RES_W-1:0]  core_result;
  logic              start_conversion, conversion_done_flag, analog_enable, diff_mode;
  logic              gain_20x, temp_sensor_sel, sample_hold, conv_finish;
  logic [7:0]        result_low, result_high;
  logic [15:0]       prev;
  int                error_cnt, checks, hc;

  sar_adc_sequencer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .converter_enable(converter_enable),
    .start_write(start_write), .auto_trigger_enable(auto_trigger_enable),
    .trigger_source_select(trigger_source_select), .prescaler_select(prescaler_select),
    .left_align_select(left_align_select), .reference_select(reference_select),
    .channel_select(channel_select), .result_low_read(result_low_read),
    .result_high_read(result_high_read), .flag_clear(flag_clear),
    .trigger_sources(trigger_sources), .core_result(core_result),
    .start_conversion(start_conversion), .conversion_done_flag(conversion_done_flag),
    .result_low(result_low), .result_high(result_high), .analog_enable(analog_enable),
    .ref_applied(ref_applied), .pos_input(pos_input), .neg_input(neg_input),
    .diff_mode(diff_mode), .gain_20x(gain_20x), .temp_sensor_sel(temp_sensor_sel),
    .sample_hold(sample_hold), .conv_finish(conv_finish));

  analog_core_model core (.sys_clk(sys_clk), .ref_applied(ref_applied), .pos_input(pos_input),
    .neg_input(neg_input), .diff_mode(diff_mode), .gain_20x(gain_20x),
    .temp_sensor_sel(temp_sensor_sel), .sample_hold(sample_hold),
    .conv_finish(conv_finish), .core_result(core_result));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic win(input int got, input int lo, input int hi, input string what);
    checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("ERROR %0t: %s took %0d cycles, window %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : win

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic pulse_start;
    @(posedge sys_clk);
    start_write <= 1'b1;
    @(posedge sys_clk);
    start_write <= 1'b0;
  endtask : pulse_start

  // cycles to sample pulse and to completion; low marks busy dropping early
  task automatic measure(output int ts, output int tf, output logic low);
    ts = -1;
    tf = -1;
    low = 1'b0;
    for (int n = 1; n <= 16000 && tf < 0; n++) begin
      @(posedge sys_clk);
      #1;
      if (sample_hold === 1'b1 && ts < 0) ts = n;
      if (start_conversion !== 1'b1 && conv_finish !== 1'b1) low = 1'b1;
      if (conv_finish === 1'b1) tf = n;
    end
    if (tf < 0) begin
      error_cnt++;
      $display("ERROR %0t: no completion seen", $time);
      tally_and_finish;
    end
  endtask : measure

  function automatic logic [9:0] expv(input logic [1:0] r, input logic [5:0] c);
    logic [2:0] p;
    logic [2:0] q;
    logic       d;
    logic       t;
    int         k;
    t = (c === TEMP_CODE);
    d = (c >= DIFF_LO && c <= DIFF_HI);
    p = c[2:0];
    q = 3'h0;
    k = c[4:1] - 4;
    if (d && k < 7) begin
      p = k[2:0];
      q = p + 3'h1;
    end else if (d) begin
      p = (k < 9) ? k - 7 : k - 4;
      q = COMMON_IN;
    end
    if (t) p = 3'h0;
    return {r, t, d, d & c[0], p, d ? q[1:0] : 2'h0};
  endfunction : expv

  function automatic logic [15:0] align(input logic [9:0] v, input logic l);
    return l ? {v, 6'h00} : {6'h00, v};
  endfunction : align

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_first;
    int ts, tf;
    logic lo;
    @(posedge sys_clk);
    channel_select <= 6'h05;
    tick(3);
    #1;
    chk(analog_enable, 1'b0, "analog enable off");
    @(posedge sys_clk);
    converter_enable <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      @(posedge sys_clk);
      reference_select <= r[1:0];
      tick(3);
      #1;
      chk(ref_applied, r[1:0], "reference");
    end
    @(posedge sys_clk);
    reference_select <= REF_EXT;
    tick(3);
    #1;
    chk({analog_enable, pos_input}, 4'hd, "path");
    pulse_start;
    #1;
    chk(start_conversion, 1'b1, "busy");
    measure(ts, tf, lo);
    win(ts, 27 * hc, 29 * hc + 4, "first sample");
    win(tf, 50 * hc, 52 * hc + 4, "first total");
    tick(1);
    #1;
    chk({start_conversion, conversion_done_flag}, 2'h1, "done");
    chk({result_high, result_low}, align(expv(REF_EXT, 6'h05), 1'b0), "result");
    $display("test first done");
  endtask : t_first

  task automatic t_lock;
    int ts, tf;
    logic lo;
    @(posedge sys_clk);
    flag_clear <= 1'b1;
    @(posedge sys_clk);
    flag_clear <= 1'b0;
    #1;
    chk(conversion_done_flag, 1'b0, "flag clear");
    prev = {result_high, result_low};
    @(posedge sys_clk);
    result_low_read <= 1'b1;
    channel_select <= 6'h09;
    reference_select <= REF_INT;
    left_align_select <= 1'b1;
    @(posedge sys_clk);
    result_low_read <= 1'b0;
    pulse_start;
    measure(ts, tf, lo);
    win(ts, 3 * hc, 5 * hc + 4, "normal sample");
    win(tf, 26 * hc, 28 * hc + 4, "normal total");
    tick(1);
    #1;
    chk({result_high, result_low}, prev, "blocked result");
    chk(conversion_done_flag, 1'b1, "flag while blocked");
    @(posedge sys_clk);
    result_high_read <= 1'b1;
    channel_select <= TEMP_CODE;
    @(posedge sys_clk);
    result_high_read <= 1'b0;
    pulse_start;
    tick(2 * hc + 4);
    channel_select <= 6'h1e;
    measure(ts, tf, lo);
    tick(1);
    #1;
    chk({result_high, result_low}, align(expv(REF_INT, TEMP_CODE), 1'b1), "temp");
    $display("test lock done");
  endtask : t_lock

  task automatic t_auto;
    int ts, tf;
    logic lo;
    @(posedge sys_clk);
    auto_trigger_enable <= 1'b1;
    trigger_source_select <= 3'h3;
    channel_select <= 6'h08;
    tick(3);
    trigger_sources[3] <= 1'b1;
    tick(3);
    #1;
    chk(start_conversion, 1'b1, "auto busy");
    measure(ts, tf, lo);
    win(ts + 3, 4 * hc + 2, 4 * hc + 10, "auto sample");
    win(tf + 3, 27 * hc + 2, 27 * hc + 10, "auto total");
    tick(3 * hc);
    #1;
    chk(start_conversion, 1'b0, "held level");
    // source flag cleared before the next event
    @(posedge sys_clk);
    trigger_sources[3] <= 1'b0;
    tick(2);
    trigger_sources[3] <= 1'b1;
    tick(8 * hc);
    trigger_sources[3] <= 1'b0;
    tick(2);
    trigger_sources[3] <= 1'b1;
    measure(ts, tf, lo);
    tick(3 * hc);
    #1;
    chk(start_conversion, 1'b0, "edge while busy");
    chk({result_high, result_low}, align(expv(REF_INT, 6'h08), 1'b1), "pair");
    @(posedge sys_clk);
    trigger_sources[3] <= 1'b0;
    $display("test auto done");
  endtask : t_auto

  task automatic t_free;
    int ts, tf;
    logic lo;
    @(posedge sys_clk);
    trigger_source_select <= SRC_SELF;
    left_align_select <= 1'b0;
    channel_select <= 6'h1e;
    tick(2);
    pulse_start;
    measure(ts, tf, lo);
    @(posedge sys_clk);
    channel_select <= 6'h09;
    #1;
    chk({result_high, result_low}, align(expv(REF_INT, 6'h1e), 1'b0), "free 1");
    measure(ts, tf, lo);
    win(ts, 5 * hc - 3, 5 * hc + 3, "free sample");
    win(tf, 28 * hc - 3, 28 * hc + 3, "free total");
    chk(lo, 1'b0, "busy held");
    tick(1);
    #1;
    chk({result_high, result_low}, align(expv(REF_INT, 6'h1e), 1'b0), "free 2");
    measure(ts, tf, lo);
    tick(1);
    #1;
    chk({result_high, result_low}, align(expv(REF_INT, 6'h09), 1'b0), "free 3");
    @(posedge sys_clk);
    converter_enable <= 1'b0;
    auto_trigger_enable <= 1'b0;
    tick(3);
    #1;
    chk(start_conversion, 1'b0, "abort");
    $display("test free done");
  endtask : t_free

  task automatic t_prescale;
    int ts, tf;
    logic lo;
    // slowest ratio still keeps the converter clock under its ceiling
    hc = 128;
    @(posedge sys_clk);
    prescaler_select <= 3'h7;
    converter_enable <= 1'b1;
    tick(2);
    pulse_start;
    measure(ts, tf, lo);
    win(ts, 27 * hc, 29 * hc + 4, "slow sample");
    win(tf, 50 * hc, 52 * hc + 4, "slow first");
    $display("test prescale done");
  endtask : t_prescale

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    rst_n = 1'b0;
    {converter_enable, start_write, auto_trigger_enable, left_align_select} = 4'h0;
    {result_low_read, result_high_read, flag_clear} = 3'h0;
    trigger_source_select = 3'h0;
    reference_select = 2'h0;
    channel_select = 6'h00;
    trigger_sources = '0;
    // divide by 128 keeps the converter clock under its ceiling
    prescaler_select = 3'h6;
    hc = 64;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_first;
    t_lock;
    t_auto;
    t_free;
    t_prescale;
    tally_and_finish;
  end
endmodule : sar_adc_sequencer_bench
